/* design/sbc_status_defs.vh */
// Register offsets, field positions, reset values and timing counts of the status bank
`ifndef SBC_STATUS_DEFS_VH
`define SBC_STATUS_DEFS_VH
`define OFS_DEVICE_INFO 7'h43
`define OFS_XCVR_FAULT 7'h44
`define OFS_LIN2_FAULT 7'h45
`define OFS_WAKE_SRC 7'h46
`define OFS_GPIO_WAKE 7'h47
`define RESET_VALUE 8'h00
`define PRIOR_CLEARED 2'h0
`define PRIOR_FAILURE 2'h1
`define PRIOR_SLEEP 2'h2
`define FAULT_NONE 2'h0
`define FAULT_THERMAL 2'h1
`define FAULT_TXD_DOM 2'h2
`define FAULT_BUS_DOM 2'h3
`define LIN_FAULT_MSB 6
`define CAN_FAULT_MSB 2
`define LIN2_FAULT_MSB 2
`define CAN_UV_BIT 0
`define GPIO2_WAKE_BIT 5
`define GPIO1_WAKE_BIT 4
`define WD_COUNT_MAX 2'h2
`define CLK_PERIOD_NS 50
`define TX_ENABLE_TIME_NS 10000
`define TX_ENABLE_CYCLES ((`TX_ENABLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* design/sbc_bus_wake_status_regs.v */
// Status register bank: prior state, watchdog count, transceiver faults and wake flags
//
// Operation
// - Prior-state code 10 after sleep exit, 01 after failure restart or fail-safe.
// - Illegal stop-to-sleep or sleep without wake source records failure code.
// - Sleep attempt with wake flags still set still reports sleep code.
// - Watchdog failure counter clears on good trigger and when watchdog stops.
// - Counter clears on sleep or fail-safe stop unless caused by watchdog failure.
// - No other status flag clears itself; host clears them.
// - Invalid-command flag clears only by host serial command.
// - Configurations 2 and 4 freeze counter after failure until good trigger or a stop that clears the counter.
// - Configuration 0 first watchdog failure only restarts, no fail outputs or flag.
// - First LIN fault code in bits 6:5 of first bus status register.
// - CAN fault code in bits 2:1 of first bus status register.
// - CAN supply undervoltage sets bit 0 and disables CAN transmitter.
// - CAN supply comparator enabled only while upper CAN mode bit is 1.
// - Second LIN fault code in bits 2:1 of second bus status register.
// - TXD timeout recovers on TXD high, wake-capable or off.
// - Bus-dominant timeout recovers on recessive bus, wake-capable or off.
// - Supply undervoltage recovers once monitored supply is above threshold and TXD is high, the bus recessive, or the transceiver wake-capable or off.
// - After any recovery, transmit resumes only after TXD high for enable time.
// - Wake flags: bit7 LIN2, bit6 LIN1, bit5 CAN, bit4 timer, bits2:0 inputs.
// - Wake out of fail-safe also sets matching wake flag.
// - GPIO wake flags: bit 5 second GPIO, bit 4 first GPIO.
// - Reserved bits read zero.
// - Prior-state stays 00 until next restart; code 11 never produced.
`timescale 1ns/100ps
`include "sbc_status_defs.vh"
module sbc_bus_wake_status_regs #(
  parameter TX_EN_CYCLES = `TX_ENABLE_CYCLES
)(
  input wire REF_CLK_IN,
  input wire NRST_IN,
  input wire RD_STROBE_IN,
  input wire CLR_STROBE_IN,
  input wire [6:0] ADDR_IN,
  input wire [7:0] CLR_MASK_IN,
  input wire [2:0] CONFIG_SEL_IN,
  input wire RESTART_FROM_SLEEP_IN,
  input wire RESTART_FROM_FAILURE_IN,
  input wire ILLEGAL_SLEEP_IN,
  input wire WD_TRIGGER_OK_IN,
  input wire WD_TRIGGER_FAIL_IN,
  input wire WD_STOP_IN,
  input wire WD_STOP_BY_WATCHDOG_FAILURE_COUNT_IN,
  input wire BAD_COMMAND_IN,
  input wire [2:0] CAN_EVT_IN,
  input wire [2:0] LIN1_EVT_IN,
  input wire [2:0] LIN2_EVT_IN,
  input wire CAN_MODE_HI_IN,
  input wire CAN_SUPPLY_LOW_IN,
  input wire LIN1_SUPPLY_LOW_IN,
  input wire LIN2_SUPPLY_LOW_IN,
  input wire [2:0] TXD_HIGH_IN,
  input wire [2:0] BUS_RECESSIVE_IN,
  input wire [2:0] XCVR_ACTIVE_IN,
  input wire [7:0] WAKE_EVT_IN,
  input wire [1:0] GPIO_WAKE_EVT_IN,
  output reg [7:0] RD_DATA_OUT,
  output reg [2:0] TX_ENABLE_OUT,
  output reg FAIL_OUTPUT_PINS_OUT,
  output reg FORCE_RESTART_OUT
);

  // Index of the three transceivers
  localparam CAN = 0;
  localparam LIN1 = 1;
  localparam LIN2 = 2;
  localparam CW = 16;

  // Pin-domain inputs: two flops each
  reg [2:0] txd_s1, txd_s2, rec_s1, rec_s2, act_s1, act_s2, uv_s1, uv_s2;
  reg [1:0] prior_state_code;
  reg [1:0] watchdog_failure_count;
  reg wd_frozen;
  reg bad_command_flag;
  reg failure_flag;
  reg [1:0] first_lin_fault_code;
  reg [1:0] can_fault_code;
  reg [1:0] second_lin_fault_code;
  reg can_supply_low_flag;
  reg [7:0] wake_source_flags;
  reg [1:0] gpio_wake_flags;
  reg [2:0] faulted;
  reg [CW-1:0] txd_cnt0, txd_cnt1, txd_cnt2;
  reg [7:0] next_rd_data;
  wire [2:0] uv_now;
  wire [2:0] clr_hit;
  wire [2:0] recover;
  wire watchdog_failure_count_take;
  wire first_cfg0_fail;

  // Fault code from an event vector: thermal, TXD, bus dominant
  function [1:0] fault_code;
    input [2:0] evt;
    begin
      if (evt[0])
        fault_code = `FAULT_THERMAL;
      else if (evt[1])
        fault_code = `FAULT_TXD_DOM;
      else if (evt[2])
        fault_code = `FAULT_BUS_DOM;
      else
        fault_code = `FAULT_NONE;
    end
  endfunction

  // Host clear of a register with mask
  function hit;
    input [6:0] ofs;
    begin
      hit = CLR_STROBE_IN && (ADDR_IN == ofs);
    end
  endfunction

  // Counter has covered the transmitter enable time
  function at_limit;
    input [CW-1:0] cnt;
    begin
      at_limit = (cnt == TX_EN_CYCLES[CW-1:0]);
    end
  endfunction

  // Enable-time counter step: restart when blocked, hold at limit
  function [CW-1:0] count_step;
    input [CW-1:0] cnt;
    input blocked;
    begin
      if (blocked)
        count_step = {CW{1'b0}};
      else if (at_limit(cnt))
        count_step = cnt;
      else
        count_step = cnt + 1'b1;
    end
  endfunction

  always @(posedge REF_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      txd_s1 <= 3'h0;
      txd_s2 <= 3'h0;
      rec_s1 <= 3'h0;
      rec_s2 <= 3'h0;
      act_s1 <= 3'h0;
      act_s2 <= 3'h0;
      uv_s1 <= 3'h0;
      uv_s2 <= 3'h0;
    end
    else
    begin
      txd_s1 <= TXD_HIGH_IN;
      txd_s2 <= txd_s1;
      rec_s1 <= BUS_RECESSIVE_IN;
      rec_s2 <= rec_s1;
      act_s1 <= XCVR_ACTIVE_IN;
      act_s2 <= act_s1;
      uv_s1 <= {LIN2_SUPPLY_LOW_IN, LIN1_SUPPLY_LOW_IN, CAN_SUPPLY_LOW_IN};
      uv_s2 <= uv_s1;
    end
  end

  assign uv_now = {uv_s2[2], uv_s2[1], uv_s2[0] & CAN_MODE_HI_IN};

  assign recover = (txd_s2 | rec_s2 | ~act_s2) & ~uv_now;

  assign clr_hit = {hit(`OFS_LIN2_FAULT), hit(`OFS_XCVR_FAULT), hit(`OFS_DEVICE_INFO)};

  // Failure taken only when no good trigger and count not frozen
  assign watchdog_failure_count_take = WD_TRIGGER_FAIL_IN && !WD_TRIGGER_OK_IN && !wd_frozen;
  // Configuration 0 first failure: restart only
  assign first_cfg0_fail = watchdog_failure_count_take && (CONFIG_SEL_IN == 3'h0) && (watchdog_failure_count == 2'h0);

  // Prior state, watchdog and command flags
  always @(posedge REF_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      prior_state_code <= `PRIOR_CLEARED;
      watchdog_failure_count <= 2'h0;
      wd_frozen <= 1'b0;
      bad_command_flag <= 1'b0;
      failure_flag <= 1'b0;
      FAIL_OUTPUT_PINS_OUT <= 1'b0;
      FORCE_RESTART_OUT <= 1'b0;
    end
    else
    begin
      FORCE_RESTART_OUT <= 1'b0;
      if (RESTART_FROM_FAILURE_IN || ILLEGAL_SLEEP_IN)
        prior_state_code <= `PRIOR_FAILURE;
      // sleep code, even with wake flags set
      else if (RESTART_FROM_SLEEP_IN)
        prior_state_code <= `PRIOR_SLEEP;
      else if (clr_hit[0] && CLR_MASK_IN[7])
        prior_state_code <= `PRIOR_CLEARED;
      if (BAD_COMMAND_IN)
        bad_command_flag <= 1'b1;
      else if (clr_hit[0] && CLR_MASK_IN[1])
        bad_command_flag <= 1'b0;
      if (WD_TRIGGER_OK_IN)
      begin
        watchdog_failure_count <= 2'h0;
        wd_frozen <= 1'b0;
      end
      else if (watchdog_failure_count_take)
      begin
        // freeze in configurations 2 and 4
        wd_frozen <= (CONFIG_SEL_IN == 3'h2) || (CONFIG_SEL_IN == 3'h4);
        if (watchdog_failure_count != `WD_COUNT_MAX)
          watchdog_failure_count <= watchdog_failure_count + 2'h1;
        // configuration 0 first failure restarts only
        if (first_cfg0_fail)
          FORCE_RESTART_OUT <= 1'b1;
        else
        begin
          failure_flag <= 1'b1;
          FAIL_OUTPUT_PINS_OUT <= 1'b1;
        end
      end
      // stop clears unless watchdog caused it
      else if (WD_STOP_IN && !WD_STOP_BY_WATCHDOG_FAILURE_COUNT_IN)
      begin
        watchdog_failure_count <= 2'h0;
        wd_frozen <= 1'b0;
      end
      // failure flag cleared only by host, set wins
      if (clr_hit[0] && CLR_MASK_IN[0] && !(watchdog_failure_count_take && !first_cfg0_fail))
        failure_flag <= 1'b0;
    end
  end

  // Transceiver faults and transmitter enable
  always @(posedge REF_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      first_lin_fault_code <= `FAULT_NONE;
      can_fault_code <= `FAULT_NONE;
      second_lin_fault_code <= `FAULT_NONE;
      can_supply_low_flag <= 1'b0;
      faulted <= 3'h0;
      txd_cnt0 <= {CW{1'b0}};
      txd_cnt1 <= {CW{1'b0}};
      txd_cnt2 <= {CW{1'b0}};
      TX_ENABLE_OUT <= 3'h0;
    end
    else
    begin
      // CAN code, set wins over clear
      if (|CAN_EVT_IN)
        can_fault_code <= fault_code(CAN_EVT_IN);
      else if (clr_hit[1] && CLR_MASK_IN[2])
        can_fault_code <= `FAULT_NONE;
      if (|LIN1_EVT_IN)
        first_lin_fault_code <= fault_code(LIN1_EVT_IN);
      else if (clr_hit[1] && CLR_MASK_IN[6])
        first_lin_fault_code <= `FAULT_NONE;
      if (|LIN2_EVT_IN)
        second_lin_fault_code <= fault_code(LIN2_EVT_IN);
      else if (clr_hit[2] && CLR_MASK_IN[2])
        second_lin_fault_code <= `FAULT_NONE;
      if (uv_now[CAN])
        can_supply_low_flag <= 1'b1;
      else if (clr_hit[1] && CLR_MASK_IN[`CAN_UV_BIT])
        can_supply_low_flag <= 1'b0;
      faulted[CAN] <= (|CAN_EVT_IN) | uv_now[CAN] | (faulted[CAN] & ~recover[CAN]);
      faulted[LIN1] <= (|LIN1_EVT_IN) | uv_now[LIN1] | (faulted[LIN1] & ~recover[LIN1]);
      faulted[LIN2] <= (|LIN2_EVT_IN) | uv_now[LIN2] | (faulted[LIN2] & ~recover[LIN2]);
      // TXD high for enable time before transmit
      txd_cnt0 <= count_step(txd_cnt0, faulted[CAN] || !txd_s2[CAN]);
      txd_cnt1 <= count_step(txd_cnt1, faulted[LIN1] || !txd_s2[LIN1]);
      txd_cnt2 <= count_step(txd_cnt2, faulted[LIN2] || !txd_s2[LIN2]);
      TX_ENABLE_OUT[CAN] <= ~uv_now[CAN] & ~faulted[CAN] & (at_limit(txd_cnt0) | TX_ENABLE_OUT[CAN]);
      TX_ENABLE_OUT[LIN1] <= ~faulted[LIN1] & (at_limit(txd_cnt1) | TX_ENABLE_OUT[LIN1]);
      TX_ENABLE_OUT[LIN2] <= ~faulted[LIN2] & (at_limit(txd_cnt2) | TX_ENABLE_OUT[LIN2]);
    end
  end

  // Wake flags: clear on read, new events kept
  always @(posedge REF_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      wake_source_flags <= `RESET_VALUE;
      gpio_wake_flags <= 2'h0;
    end
    else
    begin
      // wake source latch, includes fail-safe wakes, set wins
      if (RD_STROBE_IN && ADDR_IN == `OFS_WAKE_SRC)
        wake_source_flags <= WAKE_EVT_IN & 8'hf7;
      else
        wake_source_flags <= (wake_source_flags | WAKE_EVT_IN) & 8'hf7;
      if (RD_STROBE_IN && ADDR_IN == `OFS_GPIO_WAKE)
        gpio_wake_flags <= GPIO_WAKE_EVT_IN;
      else
        gpio_wake_flags <= gpio_wake_flags | GPIO_WAKE_EVT_IN;
    end
  end

  always @*
  begin
    next_rd_data = 8'h00;
    case (ADDR_IN)
      `OFS_DEVICE_INFO:
        next_rd_data = {prior_state_code, 2'h0, watchdog_failure_count, bad_command_flag, failure_flag};
      `OFS_XCVR_FAULT:
        next_rd_data = {1'b0, first_lin_fault_code, 2'h0, can_fault_code, can_supply_low_flag};
      `OFS_LIN2_FAULT:
        next_rd_data = {5'h00, second_lin_fault_code, 1'b0};
      `OFS_WAKE_SRC:
        next_rd_data = wake_source_flags;
      `OFS_GPIO_WAKE:
        next_rd_data = {2'h0, gpio_wake_flags, 4'h0};
      default:
        next_rd_data = 8'h00;
    endcase
  end

  always @(posedge REF_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      RD_DATA_OUT <= `RESET_VALUE;
    else if (RD_STROBE_IN)
      RD_DATA_OUT <= next_rd_data;
  end

endmodule

/* tb/sbc_status_chk.sv */
// Port checker for the status bank
`timescale 1ns/100ps
module sbc_status_chk #(
  parameter TX_EN_CYCLES = 4
)(
  input wire REF_CLK_IN,
  input wire NRST_IN,
  input wire RD_STROBE_IN,
  input wire [6:0] ADDR_IN,
  input wire [2:0] CONFIG_SEL_IN,
  input wire WD_TRIGGER_FAIL_IN,
  input wire CAN_MODE_HI_IN,
  input wire CAN_SUPPLY_LOW_IN,
  input wire [2:0] CAN_EVT_IN,
  input wire [2:0] TXD_HIGH_IN,
  input wire [7:0] RD_DATA_OUT,
  input wire [2:0] TX_ENABLE_OUT,
  input wire FAIL_OUTPUT_PINS_OUT,
  input wire FORCE_RESTART_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  reg [9:0] txd_cnt;
  reg [7:0] rsv;
  // Cycles TXD has stayed high
  always @(posedge REF_CLK_IN or negedge NRST_IN)
    if (!NRST_IN)
      txd_cnt <= 10'h000;
    else if (!TXD_HIGH_IN[0])
      txd_cnt <= 10'h000;
    else if (txd_cnt != 10'h3ff)
      txd_cnt <= txd_cnt + 10'h001;
  // Bits that must read zero per address
  always @*
    case (ADDR_IN)
      7'h43: rsv = 8'h30;
      7'h44: rsv = 8'h98;
      7'h45: rsv = 8'hf9;
      7'h46: rsv = 8'h08;
      7'h47: rsv = 8'hcf;
      default: rsv = 8'hff;
    endcase
  chk_restart_one_cycle: assert property (FORCE_RESTART_OUT |=> !FORCE_RESTART_OUT)
    else $error("restart pulse longer than one cycle");
  chk_restart_cause: assert property ($rose(FORCE_RESTART_OUT) |-> $past(WD_TRIGGER_FAIL_IN))
    else $error("restart without watchdog failure");
  chk_cfg0_no_fail: assert property ($rose(FORCE_RESTART_OUT) |-> !$rose(FAIL_OUTPUT_PINS_OUT))
    else $error("fail output raised with forced restart");
  chk_fail_sticky: assert property (FAIL_OUTPUT_PINS_OUT |=> FAIL_OUTPUT_PINS_OUT)
    else $error("fail output dropped");
  chk_uv_tx_off: assert property ((CAN_MODE_HI_IN && CAN_SUPPLY_LOW_IN) [*6] |-> !TX_ENABLE_OUT[0])
    else $error("CAN transmitter on during undervoltage");
  chk_tx_enable_wait: assert property ($rose(TX_ENABLE_OUT[0]) |-> txd_cnt >= TX_EN_CYCLES)
    else $error("transmitter enabled too early");
  chk_reserved_zero: assert property (RD_STROBE_IN |=> (RD_DATA_OUT & $past(rsv)) == 8'h00)
    else $error("reserved or unmapped bits not zero");
  chk_rd_data_hold: assert property (!RD_STROBE_IN |=> $stable(RD_DATA_OUT))
    else $error("read data changed without read");
  chk_fault_tx_off: assert property ((|CAN_EVT_IN) |=> ##1 !TX_ENABLE_OUT[0])
    else $error("CAN transmitter on after fault");
  chk_prior_not_reserved: assert property (RD_STROBE_IN && ADDR_IN == 7'h43 |=> RD_DATA_OUT[7:6] != 2'h3)
    else $error("reserved prior-state code read");
  cover property ($rose(FORCE_RESTART_OUT));
  cover property ($rose(TX_ENABLE_OUT[0]));
  cover property (RD_STROBE_IN && ADDR_IN == 7'h46);
endmodule

/* tb/sbc_host_model.sv */
// Host side: register reads, clear commands and TXD level
`timescale 1ns/100ps
module sbc_host_model (
  input wire clk_in,
  output reg rd_out,
  output reg clr_out,
  output reg [6:0] addr_out,
  output reg [7:0] mask_out,
  output reg [2:0] txd_high_out
);
  initial
  begin
    rd_out = 1'b0;
    clr_out = 1'b0;
    addr_out = 7'h00;
    mask_out = 8'h00;
    txd_high_out = 3'h7;
  end
  task read(input [6:0] a);
    begin
      @(posedge clk_in) rd_out <= 1'b1;
      addr_out <= a;
      @(posedge clk_in) rd_out <= 1'b0;
    end
  endtask
  task clear(input [6:0] a, input [7:0] m);
    begin
      @(posedge clk_in) clr_out <= 1'b1;
      addr_out <= a;
      mask_out <= m;
      @(posedge clk_in) clr_out <= 1'b0;
    end
  endtask
  task drive_txd(input [2:0] t);
    begin
      @(posedge clk_in) txd_high_out <= t;
    end
  endtask
endmodule

/* tb/sbc_bus_wake_status_regs_tb_top.sv */
// Self-checking bench for the status bank
`timescale 1ns/100ps
module sbc_bus_wake_status_regs_tb_top;
  reg clk, nrst, mode_hi, uv, rd_d1, rd_d2, stop_wd;
  reg [2:0] cfg, ce, l1e, l2e, rec;
  reg [6:0] ev;
  reg [7:0] wk, v;
  reg [1:0] gp;
  reg [7:0] exp_q[$];
  wire rd, clr, fo, frst;
  wire [6:0] addr;
  wire [7:0] mask, rdata;
  wire [2:0] txd, txen;
  integer failures, samples_checked, cycles, seed, i, restarts;
  sbc_host_model host (.clk_in(clk), .rd_out(rd), .clr_out(clr), .addr_out(addr), .mask_out(mask),
    .txd_high_out(txd));
  sbc_bus_wake_status_regs #(.TX_EN_CYCLES(4)) uut (.REF_CLK_IN(clk), .NRST_IN(nrst), .RD_STROBE_IN(rd),
    .CLR_STROBE_IN(clr), .ADDR_IN(addr), .CLR_MASK_IN(mask), .CONFIG_SEL_IN(cfg), .RESTART_FROM_SLEEP_IN(ev[0]),
    .RESTART_FROM_FAILURE_IN(ev[1]), .ILLEGAL_SLEEP_IN(ev[2]), .WD_TRIGGER_OK_IN(ev[3]),
    .WD_TRIGGER_FAIL_IN(ev[4]), .WD_STOP_IN(ev[5]), .WD_STOP_BY_WATCHDOG_FAILURE_COUNT_IN(stop_wd), .BAD_COMMAND_IN(ev[6]),
    .CAN_EVT_IN(ce), .LIN1_EVT_IN(l1e), .LIN2_EVT_IN(l2e), .CAN_MODE_HI_IN(mode_hi), .CAN_SUPPLY_LOW_IN(uv),
    .LIN1_SUPPLY_LOW_IN(1'b0), .LIN2_SUPPLY_LOW_IN(1'b0), .TXD_HIGH_IN(txd), .BUS_RECESSIVE_IN(rec),
    .XCVR_ACTIVE_IN(3'h7), .WAKE_EVT_IN(wk), .GPIO_WAKE_EVT_IN(gp), .RD_DATA_OUT(rdata),
    .TX_ENABLE_OUT(txen), .FAIL_OUTPUT_PINS_OUT(fo), .FORCE_RESTART_OUT(frst));
  task check(input [7:0] seen, input [7:0] want);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== want)
      begin
        failures = failures + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, want);
      end
    end
  endtask
  task rd_exp(input [6:0] a, input [7:0] e);
    begin
      exp_q.push_back(e);
      host.read(a);
    end
  endtask
  task pulse(input [6:0] p);
    begin
      @(posedge clk) ev <= p;
      @(posedge clk) ev <= 7'h00;
    end
  endtask
  task test_done;
    begin
      if (failures == 0 && samples_checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Read data lands on the edge that takes the request; checked on the falling edge after the next rising edge
  always @(posedge clk)
  begin
    rd_d1 <= rd;
    rd_d2 <= rd_d1;
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      failures = failures + 1;
      test_done;
    end
  end
  always @(negedge clk)
    if (rd_d2 === 1'b1)
      check(rdata, exp_q.pop_front());
  // Forced restarts seen on the output
  always @(negedge clk)
    if (frst === 1'b1)
      restarts = restarts + 1;
  initial
  begin
    {nrst, mode_hi, uv, rd_d1, rd_d2, stop_wd, cfg, ce, l1e, l2e, ev, wk, gp} = 0;
    rec = 3'h7;
    restarts = 0;
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    seed = 11;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (16) @(posedge clk);
    check({5'h00, txen}, 8'h07);
    for (i = 3; i < 9; i = i + 1)
      rd_exp(7'h40 + i[6:0], 8'h00);
    for (i = 0; i < 4; i = i + 1)
    begin
      v = $random(seed);
      @(posedge clk) wk <= v;
      gp <= v[1:0];
      @(posedge clk) wk <= 8'h00;
      gp <= 2'h0;
      rd_exp(7'h46, v & 8'hf7);
      rd_exp(7'h47, {2'h0, v[1:0], 4'h0});
      rd_exp(7'h46, 8'h00);
    end
    fork
      rd_exp(7'h46, 8'h00);
      pulse(7'h00);
      @(posedge clk) wk <= 8'h01;
    join
    wk <= 8'h00;
    rd_exp(7'h46, 8'h01);
    for (i = 1; i < 4; i = i + 1)
    begin
      v = 8'h01 << (i - 1);
      @(posedge clk) {ce, l1e, l2e} <= {3{v[2:0]}};
      @(posedge clk) {ce, l1e, l2e} <= 9'h000;
      rd_exp(7'h44, {1'b0, i[1:0], 2'b00, i[1:0], 1'b0});
      rd_exp(7'h44, {1'b0, i[1:0], 2'b00, i[1:0], 1'b0});
      rd_exp(7'h45, {5'h00, i[1:0], 1'b0});
    end
    host.clear(7'h44, 8'h45);
    host.clear(7'h45, 8'h04);
    rd_exp(7'h44, 8'h00);
    rd_exp(7'h45, 8'h00);
    @(posedge clk) mode_hi <= 1'b1;
    uv <= 1'b1;
    repeat (8) @(posedge clk);
    rd_exp(7'h44, 8'h01);
    check({7'h00, txen[0]}, 8'h00);
    @(posedge clk) uv <= 1'b0;
    mode_hi <= 1'b0;
    repeat (4) @(posedge clk);
    host.clear(7'h44, 8'h01);
    @(posedge clk) uv <= 1'b1;
    repeat (8) @(posedge clk);
    rd_exp(7'h44, 8'h00);
    uv <= 1'b0;
    // CAN TXD timeout with bus held dominant: only TXD high recovers
    host.drive_txd(3'h6);
    rec <= 3'h6;
    repeat (4) @(posedge clk);
    ce <= 3'h2;
    @(posedge clk) ce <= 3'h0;
    repeat (6) @(posedge clk);
    check({7'h00, txen[0]}, 8'h00);
    host.drive_txd(3'h7);
    repeat (4) @(posedge clk);
    check({7'h00, txen[0]}, 8'h00);
    repeat (6) @(posedge clk);
    check({7'h00, txen[0]}, 8'h01);
    rec <= 3'h7;
    rd_exp(7'h44, 8'h04);
    pulse(7'h01);
    rd_exp(7'h43, 8'h80);
    pulse(7'h05);
    rd_exp(7'h43, 8'h40);
    host.clear(7'h43, 8'h80);
    rd_exp(7'h43, 8'h00);
    pulse(7'h10);
    rd_exp(7'h43, 8'h04);
    check({7'h00, fo}, 8'h00);
    pulse(7'h08);
    rd_exp(7'h43, 8'h00);
    pulse(7'h10);
    pulse(7'h20);
    rd_exp(7'h43, 8'h00);
    pulse(7'h40);
    rd_exp(7'h43, 8'h02);
    rd_exp(7'h43, 8'h02);
    host.clear(7'h43, 8'h02);
    rd_exp(7'h43, 8'h00);
    @(posedge clk) cfg <= 3'h2;
    pulse(7'h10);
    pulse(7'h10);
    rd_exp(7'h43, 8'h05);
    check({7'h00, fo}, 8'h01);
    pulse(7'h08);
    rd_exp(7'h43, 8'h01);
    pulse(7'h10);
    stop_wd <= 1'b1;
    pulse(7'h20);
    rd_exp(7'h43, 8'h05);
    stop_wd <= 1'b0;
    pulse(7'h20);
    rd_exp(7'h43, 8'h01);
    repeat (4) @(posedge clk);
    check(restarts[7:0], 8'h02);
    check(8'(exp_q.size()), 8'h00);
    test_done;
  end
endmodule
bind sbc_bus_wake_status_regs sbc_status_chk #(.TX_EN_CYCLES(TX_EN_CYCLES)) chk (.REF_CLK_IN(REF_CLK_IN),
  .NRST_IN(NRST_IN), .RD_STROBE_IN(RD_STROBE_IN), .ADDR_IN(ADDR_IN), .CONFIG_SEL_IN(CONFIG_SEL_IN),
  .WD_TRIGGER_FAIL_IN(WD_TRIGGER_FAIL_IN), .CAN_MODE_HI_IN(CAN_MODE_HI_IN), .CAN_SUPPLY_LOW_IN(CAN_SUPPLY_LOW_IN),
  .TXD_HIGH_IN(TXD_HIGH_IN), .RD_DATA_OUT(RD_DATA_OUT), .TX_ENABLE_OUT(TX_ENABLE_OUT),
  .FAIL_OUTPUT_PINS_OUT(FAIL_OUTPUT_PINS_OUT), .FORCE_RESTART_OUT(FORCE_RESTART_OUT), .CAN_EVT_IN(CAN_EVT_IN));
